// file: parallel_config_loader_map.svh
// Offsets, field positions, reset values and timing counts of the parallel configuration loader.
// Assumes a 20 MHz system clock; times are kept in ns and turned into cycles here.
`ifndef PARALLEL_CONFIG_LOADER_MAP_SVH
`define PARALLEL_CONFIG_LOADER_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define REG_CTRL_OFS        8'h00
`define REG_LENGTH_OFS      8'h04
`define REG_CHECK_OFS       8'h08
`define REG_STATE_OFS       8'h0c
`define REG_COUNT_OFS       8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_INIT_CLK_BIT   0
`define STATE_ERROR_BIT     8
`define STATE_DONE_BIT      9
`define STATE_USER_BIT      10
`define CTRL_RESET          1'h0
`define LENGTH_RESET        32'h00000000
`define CHECK_RESET         32'h00000000

// ****************************************************************
// Timing (ns figures as specified, cycles derived from the clock)
// ****************************************************************
`define CLK_PERIOD_NS       50
`define REQ_TO_LOW_MAX_NS   600
`define REQ_TO_LOW_CYCLES   (`REQ_TO_LOW_MAX_NS / `CLK_PERIOD_NS)
`define STATUS_LOW_MIN_NS   268000
`define STATUS_LOW_MAX_NS   1506000
`define STATUS_LOW_CYCLES   ((`STATUS_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_OSC_MIN_NS     175000
`define INIT_OSC_MAX_NS     437000
`define INIT_OSC_CYCLES     ((`INIT_OSC_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WORD_CLK_MIN_PER_NS 10
`define INIT_CLK_EN_NS      (4 * `WORD_CLK_MIN_PER_NS)
`define INIT_CLK_EN_CYCLES  ((`INIT_CLK_EN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_USER_EDGES     8576
`define DONE_FALL_EDGES     2

`endif

// file: parallel_config_loader_pkg.sv
// Types of the parallel configuration loader.
// Assumes the map header is included by every user of the timing counts.
package parallel_config_loader_pkg;

	// Load sequence, one-hot
	typedef enum logic [6:0]
	{
		ST_CLEAR  = 7'h01,
		ST_HOLD   = 7'h02,
		ST_LOAD   = 7'h04,
		ST_FINISH = 7'h08,
		ST_INIT   = 7'h10,
		ST_USER   = 7'h20,
		ST_ERROR  = 7'h40
	} load_state_t;

endpackage

// file: parallel_config_loader.sv
// Device-side sequencer for the one-word-per-clock parallel configuration load.
// Assumes the host drives request, word clock and data asynchronously to clk,
// and that the status line is an open-drain wire resolved outside this module.
//
// What this block does
// - Sequence assumes one word per word clock
// - Load-complete low soon after request falls
// - Status low soon after request falls
// - Status low between 268 and 1506us
// - Release status soon after request rises
// - Capture each word on rising clock edge
// - Oscillator init: user mode 175-437us later
// - Init clock enabled 4 periods after done
// - User init clock: enable plus 8576 periods
// - Load-complete high only after clean image
// - User mode: all lines high, request restarts
`timescale 1ns/1ps
`include "parallel_config_loader_map.svh"

module parallel_config_loader
#(
	parameter int unsigned STATUS_LOW_CYCLES = `STATUS_LOW_CYCLES
)
(
	// Clock, reset, enable
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                ce,
	// Host pins
	input  wire logic                cfg_request_n,
	input  wire logic                cfg_word_clock,
	input  wire logic [31:0]         cfg_data,
	input  wire logic                user_supplied_init_clock,
	input  wire logic                status_n_in,
	output logic                     status_n_out,
	output logic                     status_n_oe,
	output logic                     load_done,
	output logic                     user_mode,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_write,
	input  wire logic                reg_read,
	output logic [31:0]              reg_rdata
);
	import parallel_config_loader_pkg::*;

	localparam int SYNC_W = 36;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [SYNC_W-1:0] sync_a_reg;
	logic [SYNC_W-1:0] sync_b_reg;
	logic              wclk_prev_reg;
	logic              uclk_prev_reg;
	logic              req_n_s;
	logic              status_s;
	logic              wclk_s;
	logic              uclk_s;
	logic [31:0]       data_s;
	logic              wclk_rise;
	logic              wclk_fall;
	logic              uclk_rise;

	// Every pin bit gets its own two-stage chain
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++)
		begin : g_sync
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					sync_a_reg[g] <= 1'h0;
					sync_b_reg[g] <= 1'h0;
				end
				else if (ce)
				begin
					sync_a_reg[g] <= (g == 35) ? cfg_request_n :
						(g == 34) ? status_n_in :
						(g == 33) ? cfg_word_clock :
						(g == 32) ? user_supplied_init_clock : cfg_data[g % 32];
					sync_b_reg[g] <= sync_a_reg[g];
				end
			end
		end
	endgenerate

	assign req_n_s  = sync_b_reg[35];
	assign status_s = sync_b_reg[34];
	assign wclk_s   = sync_b_reg[33];
	assign uclk_s   = sync_b_reg[32];
	assign data_s   = sync_b_reg[31:0];

	// Edge history taken from the second stage only
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wclk_prev_reg <= 1'h0;
			uclk_prev_reg <= 1'h0;
		end
		else if (ce)
		begin
			wclk_prev_reg <= wclk_s;
			uclk_prev_reg <= uclk_s;
		end
	end

	// Data shares the clock's latency, so word and edge line up
	// rising and falling edge detect
	assign wclk_rise = wclk_s & ~wclk_prev_reg;
	assign wclk_fall = ~wclk_s & wclk_prev_reg;
	assign uclk_rise = uclk_s & ~uclk_prev_reg;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic        init_clk_opt_reg;
	logic [31:0] length_reg;
	logic [31:0] check_reg;

	// Software settings; a new value counts at once, also in a load under way
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			init_clk_opt_reg <= `CTRL_RESET;
			length_reg       <= `LENGTH_RESET;
			check_reg        <= `CHECK_RESET;
		end
		else if (ce && reg_write)
		begin
			if (reg_addr == `REG_CTRL_OFS)
				init_clk_opt_reg <= reg_wdata[`CTRL_INIT_CLK_BIT];
			if (reg_addr == `REG_LENGTH_OFS)
				length_reg <= reg_wdata;
			if (reg_addr == `REG_CHECK_OFS)
				check_reg <= reg_wdata;
		end
	end

	// ****************************************************************
	// Load sequence
	// ****************************************************************
	load_state_t state_reg;
	logic [31:0] timer_reg;
	logic [31:0] word_count_reg;
	logic [31:0] xor_reg;
	logic [1:0]  fall_count_reg;
	logic        fall_armed_reg;
	logic        last_word;
	logic [31:0] xor_next;

	assign xor_next  = xor_reg ^ data_s;
	assign last_word = (word_count_reg + 32'h1 == length_reg);

	// request low restarts from any state but ST_CLEAR, whose count runs on
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg      <= ST_CLEAR;
			timer_reg      <= 32'h0;
			word_count_reg <= 32'h0;
			xor_reg        <= 32'h0;
			fall_count_reg <= 2'h0;
			fall_armed_reg <= 1'h0;
		end
		else if (ce)
		begin
			if (!req_n_s && state_reg != ST_CLEAR)
			begin
				state_reg <= ST_CLEAR;
				timer_reg <= 32'h0;
			end
			else
			begin
				unique case (state_reg)
					// minimum low time counted from request fall
					ST_CLEAR:
					begin
						word_count_reg <= 32'h0;
						xor_reg        <= 32'h0;
						fall_count_reg <= 2'h0;
						fall_armed_reg <= 1'h0;
						if (timer_reg < STATUS_LOW_CYCLES)
							timer_reg <= timer_reg + 32'h1;
						// release once request is back high
						else if (req_n_s)
							state_reg <= ST_HOLD;
					end
					// wait while something outside holds status
					ST_HOLD:
					begin
						if (status_s)
							state_reg <= ST_LOAD;
					end
					// one word per clock, status released
					ST_LOAD:
					begin
						if (!status_s)
							state_reg <= ST_HOLD;
						else if (wclk_rise && length_reg != 32'h0)
						begin
							word_count_reg <= word_count_reg + 32'h1;
							xor_reg        <= xor_next;
							// done only with full and matching image
							if (last_word)
								state_reg <= (xor_next == check_reg) ? ST_FINISH : ST_ERROR;
						end
					end
					ST_FINISH:
					begin
						timer_reg <= 32'h0;
						// The last word's own trailing edge must not count, so a
						// fall only counts after a rise seen in this state
						if (wclk_rise)
							fall_armed_reg <= 1'h1;
						else if (wclk_fall && fall_armed_reg)
						begin
							fall_armed_reg <= 1'h0;
							fall_count_reg <= fall_count_reg + 2'h1;
							if (fall_count_reg == 2'(`DONE_FALL_EDGES - 1))
								state_reg <= ST_INIT;
						end
					end
					// oscillator path waits the minimum init time
					ST_INIT:
					begin
						if (!init_clk_opt_reg)
						begin
							if (timer_reg < 32'(`INIT_OSC_CYCLES - 1))
								timer_reg <= timer_reg + 32'h1;
							else
								state_reg <= ST_USER;
						end
						// init clock ignored until enable delay passes
						else if (timer_reg < 32'(`INIT_CLK_EN_CYCLES))
							timer_reg <= timer_reg + 32'h1;
						else if (uclk_rise)
						begin
							word_count_reg <= word_count_reg + 32'h1;
							if (word_count_reg >= length_reg + 32'(`INIT_USER_EDGES - 1))
								state_reg <= ST_USER;
						end
					end
					ST_USER:
						state_reg <= ST_USER;
					// Bad image: status stays low until a new request
					ST_ERROR:
						state_reg <= ST_ERROR;
					default:
						state_reg <= ST_CLEAR;
				endcase
			end
		end
	end

	// ****************************************************************
	// Pin outputs
	// ****************************************************************
	// Driven from the state one clock later, well inside 600 ns
	// low within two sync stages plus one
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			status_n_out <= 1'h0;
			status_n_oe  <= 1'h1;
			load_done    <= 1'h0;
			user_mode    <= 1'h0;
		end
		else if (ce)
		begin
			status_n_out <= 1'h0;
			status_n_oe  <= !req_n_s || state_reg == ST_CLEAR || state_reg == ST_ERROR;
			load_done    <= req_n_s && (state_reg == ST_FINISH || state_reg == ST_INIT ||
				state_reg == ST_USER);
			user_mode    <= req_n_s && state_reg == ST_USER;
		end
	end

	// ****************************************************************
	// Register read
	// ****************************************************************
	// Unmapped offsets read zero; data stands one cycle after the strobe
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 32'h0;
		else if (ce && reg_read)
		begin
			unique case (reg_addr)
				`REG_CTRL_OFS:   reg_rdata <= {31'h0, init_clk_opt_reg};
				`REG_LENGTH_OFS: reg_rdata <= length_reg;
				`REG_CHECK_OFS:  reg_rdata <= check_reg;
				`REG_STATE_OFS:  reg_rdata <= {21'h0, user_mode, load_done,
					state_reg == ST_ERROR, 1'h0, state_reg};
				`REG_COUNT_OFS:  reg_rdata <= word_count_reg;
				default:         reg_rdata <= 32'h0;
			endcase
		end
	end

endmodule // parallel_config_loader

// file: parallel_config_loader_checker.sv
// Pin checker of the parallel configuration loader, bound below.
// Assumes one clock domain and a bench status pull far under 1000 cycles.
`timescale 1ns/1ps
`include "parallel_config_loader_map.svh"
module parallel_config_loader_checker
#(
	parameter int unsigned STATUS_LOW_CYCLES = 5360
)
(
	// System
	input wire logic clk,
	input wire logic resetn,
	// Pins watched
	input wire logic cfg_request_n,
	input wire logic user_supplied_init_clock,
	input wire logic status_n_in,
	input wire logic status_n_oe,
	input wire logic load_done,
	input wire logic user_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	int unsigned low_cnt, done_cnt, uck_cnt;
	logic uck_q;
	// Length of the current status pull
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			low_cnt <= 0;
		else
			low_cnt <= status_n_oe ? low_cnt + 1 : 0;
	// Time since load-complete and raw init clock edges; raw edges run
	// ahead of the loader's synchroniser, never behind, so bounds stay safe
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			done_cnt <= 0;
			uck_cnt <= 0;
			uck_q <= 1'b0;
		end
		else
		begin
			uck_q <= user_supplied_init_clock;
			done_cnt <= load_done ? done_cnt + 1 : 0;
			uck_cnt <= load_done ? uck_cnt + 32'(user_supplied_init_clock & !uck_q) : 0;
		end
	property p_done_low; $fell(cfg_request_n) |-> ##[0:12] !load_done; endproperty
	a_done_low: assert property (p_done_low)
		else $error("load_done late");
	property p_pull; $fell(cfg_request_n) |-> ##[0:12] status_n_oe; endproperty
	a_pull: assert property (p_pull)
		else $error("status pull late");
	property p_pull_min; $fell(status_n_oe) |-> low_cnt >= STATUS_LOW_CYCLES - 4; endproperty
	a_pull_min: assert property (p_pull_min)
		else $error("status pull short");
	property p_release; $rose(cfg_request_n) |-> ##[1:1000] !status_n_oe; endproperty
	a_release: assert property (p_release)
		else $error("status not released");
	property p_done_cause; $rose(load_done) |-> cfg_request_n && status_n_in; endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("load_done while held");
	property p_done_drop; $fell(load_done) |-> !cfg_request_n; endproperty
	a_done_drop: assert property (p_done_drop)
		else $error("load_done dropped");
	property p_user; $rose(user_mode) |-> load_done && (uck_cnt >= `INIT_USER_EDGES
		|| uck_cnt == 0 && done_cnt >= `INIT_OSC_CYCLES); endproperty
	a_user: assert property (p_user)
		else $error("user mode early");
	property p_user_drop; $fell(cfg_request_n) |-> ##[0:12] !user_mode; endproperty
	a_user_drop: assert property (p_user_drop)
		else $error("user mode kept");
	c_done: cover property ($rose(load_done));
	c_user: cover property ($rose(user_mode));
	c_held: cover property (!status_n_in && !status_n_oe);
endmodule // parallel_config_loader_checker

bind parallel_config_loader parallel_config_loader_checker
	#(.STATUS_LOW_CYCLES(STATUS_LOW_CYCLES)) u_checker (.clk(clk), .resetn(resetn),
	.cfg_request_n(cfg_request_n), .user_supplied_init_clock(user_supplied_init_clock),
	.status_n_in(status_n_in), .status_n_oe(status_n_oe), .load_done(load_done),
	.user_mode(user_mode));

// file: cfg_host_model.sv
// Host model: request, word clock, data, init clock and a pull on status.
// Assumes status_n_in is the resolved wire; all changes follow a clk edge.
`timescale 1ns/1ps
`include "parallel_config_loader_map.svh"
module cfg_host_model
(
	// System clock and status wire
	input wire logic   clk,
	input wire logic   status_n_in,
	// Host pins
	output logic        cfg_request_n,
	output logic        cfg_word_clock,
	output logic [31:0] cfg_data,
	output logic        user_supplied_init_clock,
	output logic        hold_n
);
	// Idle pins; word clock stands low outside frames
	initial
	begin
		cfg_request_n = 1'b1;
		cfg_word_clock = 1'b0;
		cfg_data = 32'h0;
		user_supplied_init_clock = 1'b0;
		hold_n = 1'b1;
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One word per slow clock, set while low
	task send(input logic [31:0] w);
		tick(1);
		cfg_data <= w;
		tick(3);
		cfg_word_clock <= 1'b1;
		tick(4);
		cfg_word_clock <= 1'b0;
		cfg_data <= ~w; // Released bus shows no stale word
	endtask
	task request();
		tick(1);
		cfg_request_n <= 1'b0;
		tick(40);
		cfg_request_n <= 1'b1;
	endtask
	// Hold status low from outside, sending a stray word meanwhile
	task postpone(input int n);
		tick(1);
		hold_n <= 1'b0;
		tick(n);
		send(32'h0bad_0bad);
		hold_n <= 1'b1;
	endtask
	// Status watched: wait 2 us after it rises
	task await_status();
		int n;
		n = 0;
		while (status_n_in !== 1'b1 && n < 5000)
		begin
			tick(1);
			n++;
		end
		tick(40);
	endtask
	// Status not watched: wait the longest status pull
	task blind_wait();
		tick(`STATUS_LOW_MAX_NS / `CLK_PERIOD_NS);
	endtask
	// Two more falling edges, clock then held low
	task two_falls();
		repeat (2) send(32'h0);
	endtask
	task init_clock(input int n);
		repeat (n)
		begin
			tick(2);
			user_supplied_init_clock <= 1'b1;
			tick(2);
			user_supplied_init_clock <= 1'b0;
		end
	endtask
endmodule // cfg_host_model

// file: parallel_config_loader_tb_top.sv
// Bench of the parallel configuration loader against the host model.
// Assumes the checker and host model files are compiled before it.
`timescale 1ns/1ps
`include "parallel_config_loader_map.svh"
module parallel_config_loader_tb_top;
	logic clk = 1'b0;
	logic resetn, ce, reg_write, reg_read, cfg_request_n, cfg_word_clock, hold_n;
	logic user_supplied_init_clock, status_n_out, status_n_oe, load_done, user_mode;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, cfg_data, d;
	int failures = 0;
	int checks = 0;
	// Open-drain status wire with pull-up
	wire status_n_in = (status_n_oe ? status_n_out : 1'b1) & hold_n;
	always #25 clk = ~clk;
	cfg_host_model host (.clk(clk), .status_n_in(status_n_in), .cfg_request_n(cfg_request_n),
		.cfg_word_clock(cfg_word_clock), .cfg_data(cfg_data),
		.user_supplied_init_clock(user_supplied_init_clock), .hold_n(hold_n));
	// Short status pull keeps the run brief
	parallel_config_loader #(.STATUS_LOW_CYCLES(20)) DUT (.clk(clk), .resetn(resetn), .ce(ce),
		.cfg_request_n(cfg_request_n), .cfg_word_clock(cfg_word_clock), .cfg_data(cfg_data),
		.user_supplied_init_clock(user_supplied_init_clock), .status_n_in(status_n_in),
		.status_n_out(status_n_out), .status_n_oe(status_n_oe), .load_done(load_done),
		.user_mode(user_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// Read data stand from the cycle after the strobe until the next read
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog well past the 70k cycles the tests need
	initial
	begin
		#4600000;
		failures++;
		conclude();
	end
	initial
	begin
		resetn = 1'b0;
		{reg_write, reg_read, reg_addr, reg_wdata} = '0;
		ce = 1'b1;
		repeat (12) @(posedge clk);
		chk("reset_pull", 32'(status_n_oe), 32'h1);
		resetn <= 1'b1;
		wr(8'h14, 32'hffff_ffff);
		rd(`REG_CTRL_OFS);
		chk("ctrl_reset", d, 32'h0);
		rd(`REG_LENGTH_OFS);
		chk("length_reset", d, 32'h0);
		rd(8'h14);
		chk("unmapped", d, 32'h0);
		$display("test registers done");
		wr(`REG_LENGTH_OFS, 32'h3);
		wr(`REG_CHECK_OFS, 32'h1234_5678 ^ 32'h2468_acf0 ^ 32'h48d1_59e0);
		host.request();
		host.await_status();
		// A frozen block must miss a whole word pulse
		ce <= 1'b0;
		host.send(32'hdead_beef);
		ce <= 1'b1;
		rd(`REG_COUNT_OFS);
		chk("frozen_count", d, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			host.send(32'h1234_5678 << i);
			host.tick(30);
		end
		chk("done", 32'(load_done), 32'h1);
		rd(`REG_STATE_OFS);
		chk("state", 32'(d[10:8]), 32'h2);
		rd(`REG_COUNT_OFS);
		chk("count", d, 32'h3);
		host.two_falls();
		host.tick(3490);
		chk("user_early", 32'(user_mode), 32'h0);
		host.tick(30);
		chk("user_lines", 32'({user_mode, load_done, status_n_in}), 32'h7);
		$display("test oscillator init done");
		wr(`REG_LENGTH_OFS, 32'h2);
		wr(`REG_CHECK_OFS, 32'h0);
		host.request();
		chk("user_drop", 32'(user_mode), 32'h0);
		host.blind_wait();
		host.send(32'h1);
		host.send(32'h2);
		host.tick(6);
		rd(`REG_STATE_OFS);
		chk("error", 32'({d[10:8], status_n_oe}), 32'h3);
		$display("test bad image done");
		wr(`REG_CTRL_OFS, 32'h1);
		wr(`REG_CHECK_OFS, 32'hffff_ffff);
		host.request();
		host.postpone(60);
		host.await_status();
		host.send(32'h00ff_00ff);
		host.send(32'hff00_ff00);
		host.tick(6);
		chk("done_clean", 32'(load_done), 32'h1);
		host.two_falls();
		host.init_clock(8570);
		chk("user_early_clk", 32'(user_mode), 32'h0);
		host.init_clock(10);
		chk("user_clk", 32'(user_mode), 32'h1);
		$display("test user clock init done");
		conclude();
	end
endmodule // parallel_config_loader_tb_top
